// ===== tb/drive_operation_mode_selector_tb_top.sv
// Testbench of the operation mode selector, one task per scenario.
// Assumes the selector, its package and the operator model are compiled.
`timescale 1ns/10ps
module drive_operation_mode_selector_tb_top;
  localparam int HOLD = 20;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_alarm = 1'b0;
  logic i_drv = 1'b0;
  logic r_fwd = 1'b0;
  logic r_rev = 1'b0;
  logic [15:0] r_freq = 16'h0;
  logic [15:0] ofreq = 16'h0;
  logic [15:0] mfreq = 16'h03E8;
  logic [15:0] ocur = 16'h0;
  logic [15:0] rcur = 16'h0064;
  logic [31:0] disp = 32'h0;
  logic [3:0] be = 4'hF;
  logic [15:0] torq = 16'h0;
  logic [15:0] rtorq = 16'h0064;
  logic [31:0] o_readdata;
  logic o_waitrequest, kf, kr, ks, kl, kp, kx;
  logic [4:0] din;
  logic [1:0] dex;
  logic o_run_fwd, o_run_rev, rem_ind, loc_ind, key_ind, link_ind;
  logic scale_ind, fwd_ind, rev_ind, stop_ind, st_view, bar_view, run_st;
  logic [15:0] o_freq_cmd;
  logic [1:0] o_mode;
  logic [7:0] bar_f, bar_c, bar_t;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Clock, 100 MHz
  always #5 i_mclk = ~i_mclk;

  drive_operation_mode_selector #(.HOLD_CYC(HOLD)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(be), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_key_fwd(kf), .i_key_rev(kr),
    .i_key_stop(ks), .i_key_remloc(kl), .i_key_prg(kp), .i_key_reset(kx),
    .i_din(din), .i_din_extra(dex), .i_alarm(i_alarm),
    .i_motor_driving(i_drv), .i_remote_run_fwd(r_fwd),
    .i_remote_run_rev(r_rev), .i_remote_freq(r_freq),
    .i_display_value(disp), .i_out_freq(ofreq), .i_max_freq(mfreq),
    .i_out_current(ocur), .i_rated_current(rcur), .i_torque(torq),
    .i_rated_torque(rtorq), .o_run_fwd(o_run_fwd),
    .o_run_rev(o_run_rev), .o_freq_cmd(o_freq_cmd), .o_mode(o_mode),
    .o_remote_ind(rem_ind), .o_local_ind(loc_ind),
    .o_keypad_src_ind(key_ind), .o_link_src_ind(link_ind),
    .o_scale_ind(scale_ind), .o_fwd_ind(fwd_ind), .o_rev_ind(rev_ind),
    .o_stop_ind(stop_ind), .o_lcd_status_view(st_view),
    .o_lcd_bar_view(bar_view), .o_lcd_run_status(run_st),
    .o_bar_freq(bar_f), .o_bar_current(bar_c), .o_bar_torque(bar_t)
  );

  panel_operator_model op (
    .i_mclk(i_mclk), .o_key_fwd(kf), .o_key_rev(kr), .o_key_stop(ks),
    .o_key_remloc(kl), .o_key_prg(kp), .o_key_reset(kx), .o_din(din),
    .o_din_extra(dex)
  );

  // Single comparison point; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard; the whole run needs well under this
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // Bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= ~wr;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0) @(posedge i_mclk);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge i_mclk);
  endtask

  task automatic t_reset;
    check(o_mode, 32'(mode_sel_pkg::OP_RUNNING));
    check({rem_ind, loc_ind}, 32'h2);
    check({st_view, bar_view}, 32'h2);
    bus(1'b0, mode_sel_pkg::OFS_FUNC_HI, 32'h0);
    check(rd, mode_sel_pkg::FUNC_HI_RST);
    bus(1'b0, 5'h10, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_remote;
    r_fwd <= 1'b1;
    r_freq <= 16'h1234;
    settle();
    check({o_run_rev, o_run_fwd, o_freq_cmd}, 32'h11234);
    check({run_st, fwd_ind, stop_ind}, 32'h6);
    op.press(1, 2);
    check(o_run_rev, 32'h0);
  endtask

  // Priority terminal while running forward from the remote path
  task automatic t_priority;
    op.set_din(5'h10);
    check({rem_ind, loc_ind, key_ind}, 32'h3);
    check({o_run_fwd, o_freq_cmd}, 32'h11234);
    r_fwd <= 1'b0;
    r_freq <= 16'h0777;
    op.press(3, HOLD + 5);
    check({loc_ind, o_run_fwd, o_freq_cmd}, 32'h31234);
    op.press(2, 2);
    check({o_run_fwd, stop_ind}, 32'h1);
    op.press(1, 2);
    check({o_run_rev, rev_ind}, 32'h3);
    op.set_din(5'h00);
    check({rem_ind, o_run_rev}, 32'h2);
  endtask

  // Key hold, then the keypad run sources in local mode
  task automatic t_hold;
    op.press(3, HOLD / 2);
    check(rem_ind, 32'h1);
    op.press(3, HOLD + 5);
    check(loc_ind, 32'h1);
    for (int s = 2; s < 4; s++)
    begin
      bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'(s));
      op.press(s == 2 ? 1 : 0, 2);
      check({o_run_rev, o_run_fwd}, 32'h0);
      op.press(s == 2 ? 0 : 1, 2);
      check({o_run_rev, o_run_fwd}, s == 2 ? 32'h1 : 32'h2);
      op.press(2, 2);
      check({o_run_rev, o_run_fwd}, 32'h0);
    end
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'h0);
    op.press(0, 2);
    check(o_run_fwd, 32'h1);
    op.press(2, 2);
    op.press(3, HOLD + 5);
    check(rem_ind, 32'h1);
  endtask

  // Reverse running meets a forward-only keypad at the switch
  task automatic t_conflict;
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'(mode_sel_pkg::RSS_KEY_FWD));
    r_rev <= 1'b1;
    i_drv <= 1'b1;
    settle();
    op.set_din(5'h10);
    check({o_run_rev, o_run_fwd}, 32'h0);
    check({run_st, stop_ind}, 32'h2);
    r_rev <= 1'b0;
    i_drv <= 1'b0;
    op.set_din(5'h00);
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'h0);
  endtask

  // Alarm clears local run one edge after the mode, so wait four edges
  task automatic t_alarm;
    op.set_din(5'h10);
    op.press(0, 2);
    i_alarm <= 1'b1;
    repeat (4) @(posedge i_mclk);
    check({o_mode, o_run_fwd}, 32'h4);
    op.press(0, 2);
    check(o_run_fwd, 32'h0);
    i_alarm <= 1'b0;
    op.press(5, 2);
    op.press(0, 2);
    check({o_mode, o_run_fwd}, 32'h1);
    op.press(2, 2);
    op.set_din(5'h00);
  endtask

  // Byte lanes, extra terminal, external source and programming mode
  task automatic t_extra;
    be <= 4'h2;
    bus(1'b1, mode_sel_pkg::OFS_FUNC_HI, 32'h00002300);
    be <= 4'hF;
    bus(1'b0, mode_sel_pkg::OFS_FUNC_HI, 32'h0);
    check(rd, 32'h00002323);
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'(mode_sel_pkg::RSS_EXTERNAL));
    settle();
    check({rem_ind, key_ind}, 32'h2);
    op.set_dex(2'h1);
    check({loc_ind, key_ind}, 32'h3);
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'h0);
    op.press(4, 2);
    op.press(1, 2);
    check({o_mode, o_run_rev}, 32'h3);
    op.press(2, 2);
    op.press(4, 2);
    check({o_mode, o_run_rev}, 32'h0);
    op.set_dex(2'h0);
    check({rem_ind, loc_ind}, 32'h2);
  endtask

  // Link enables, scale threshold and the bar view
  task automatic t_display;
    for (int b = 3; b < 6; b++)
    begin
      bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'h1 << b);
      settle();
      check(link_ind, 32'h1);
    end
    disp <= mode_sel_pkg::SCALE_LIMIT;
    bus(1'b1, mode_sel_pkg::OFS_CTRL, 32'h4);
    settle();
    check({link_ind, scale_ind, st_view, bar_view}, 32'h1);
    disp <= mode_sel_pkg::SCALE_LIMIT + 32'h1;
    ofreq <= mfreq;
    ocur <= 16'h00C8;
    torq <= 16'h0064;
    settle();
    check(scale_ind, 32'h1);
    // Torque at rated is half of the 200% scale, truncated
    check({bar_f, bar_c, bar_t}, 32'hFFFF7F);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    t_reset();
    t_remote();
    t_priority();
    t_hold();
    t_conflict();
    t_alarm();
    t_extra();
    t_display();
    stop_test();
  end
endmodule // drive_operation_mode_selector_tb_top

// ===== tb/panel_operator_model.sv
// Operator model: keypad keys and the digital input terminals.
// Assumes one bench process calls its tasks, one task at a time.
`timescale 1ns/10ps
module panel_operator_model (
  // Clock
  input wire logic i_mclk,
  // Keys, high while pressed
  output logic o_key_fwd,
  output logic o_key_rev,
  output logic o_key_stop,
  output logic o_key_remloc,
  output logic o_key_prg,
  output logic o_key_reset,
  // Terminals
  output logic [4:0] o_din,
  output logic [1:0] o_din_extra
);
  logic [5:0] keys_r = 6'h00;
  // Key order: fwd, rev, stop, remloc, prg, reset
  assign {o_key_reset, o_key_prg, o_key_remloc} = keys_r[5:3];
  assign {o_key_stop, o_key_rev, o_key_fwd} = keys_r[2:0];
  logic [4:0] din_r = 5'h00;
  logic [1:0] dex_r = 2'h0;
  // Terminal levels come from one variable each, one driver apiece
  assign o_din = din_r;
  assign o_din_extra = dex_r;
  // Press, hold for cyc cycles, release, then let outputs settle
  task automatic press(input int idx, input int cyc);
    @(posedge i_mclk);
    keys_r[idx] <= 1'b1;
    repeat (cyc) @(posedge i_mclk);
    keys_r[idx] <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  // Terminal levels; bit 4 is terminal five
  task automatic set_din(input logic [4:0] v);
    @(posedge i_mclk);
    din_r <= v;
    repeat (3) @(posedge i_mclk);
  endtask
  // Extra terminal levels; bit 0 is extra a
  task automatic set_dex(input logic [1:0] v);
    @(posedge i_mclk);
    dex_r <= v;
    repeat (3) @(posedge i_mclk);
  endtask
endmodule // panel_operator_model

// ===== verilog/drive_operation_mode_selector.sv
// Operation mode and command source selector of a drive front panel.
// Assumes keys and terminals are synchronous, debounced, high when active.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module drive_operation_mode_selector #(
  parameter int unsigned HOLD_CYC = mode_sel_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Avalon-MM register port
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Keypad keys
  input wire logic i_key_fwd,
  input wire logic i_key_rev,
  input wire logic i_key_stop,
  input wire logic i_key_remloc,
  input wire logic i_key_prg,
  input wire logic i_key_reset,
  // Digital input terminals, one to five and two extra
  input wire logic [4:0] i_din,
  input wire logic [1:0] i_din_extra,
  // Drive side status and remote command path
  input wire logic i_alarm,
  input wire logic i_motor_driving,
  input wire logic i_remote_run_fwd,
  input wire logic i_remote_run_rev,
  input wire logic [15:0] i_remote_freq,
  input wire logic [31:0] i_display_value,
  // Bar graph sources
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_max_freq,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_rated_current,
  input wire logic [15:0] i_torque,
  input wire logic [15:0] i_rated_torque,
  // Effective commands
  output logic o_run_fwd,
  output logic o_run_rev,
  output logic [15:0] o_freq_cmd,
  output logic [1:0] o_mode,
  // Indicators
  output logic o_remote_ind,
  output logic o_local_ind,
  output logic o_keypad_src_ind,
  output logic o_link_src_ind,
  output logic o_scale_ind,
  output logic o_fwd_ind,
  output logic o_rev_ind,
  output logic o_stop_ind,
  // LCD view
  output logic o_lcd_status_view,
  output logic o_lcd_bar_view,
  output logic o_lcd_run_status,
  output logic [7:0] o_bar_freq,
  output logic [7:0] o_bar_current,
  output logic [7:0] o_bar_torque
);
  typedef mode_sel_pkg::op_mode_e op_mode_e;

  // True when the run source lets the keypad run in that direction
  function automatic logic dir_ok(input logic [1:0] rss, input logic reverse_run);
    dir_ok = (rss == mode_sel_pkg::RSS_KEYPAD) ||
      (rss == mode_sel_pkg::RSS_KEY_FWD && !reverse_run) ||
      (rss == mode_sel_pkg::RSS_KEY_REV && reverse_run);
  endfunction

  // Bar level, saturating at full scale
  function automatic logic [7:0] bar_level(input logic [15:0] val,
    input logic [17:0] full);
    logic [25:0] prod;
    prod = 26'(val) * 26'(mode_sel_pkg::BAR_FULL);
    if (full == '0 || 18'(val) >= full)
      bar_level = mode_sel_pkg::BAR_FULL;
    else
      bar_level = 8'(prod / 26'(full));
  endfunction

  // Rated value scaled to the 200% full scale
  function automatic logic [17:0] rated_full(input logic [15:0] rated);
    rated_full = 18'((32'(rated) * mode_sel_pkg::BAR_PCT) / 100);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        merge[8*b +: 8] = wd[8*b +: 8];
  endfunction

  // Any terminal coded for keypad priority and asserted
  function automatic logic lock_hit(input logic [55:0] codes,
    input logic [6:0] din);
    lock_hit = 1'b0;
    for (int t = 0; t < mode_sel_pkg::TERMINALS; t++)
      if (din[t] && codes[8*t +: 8] == mode_sel_pkg::LOCK_FUNC_CODE)
        lock_hit = 1'b1;
  endfunction

  logic wait_r;
  logic [31:0] ctrl_r;
  logic [31:0] func_lo_r;
  logic [31:0] func_hi_r;
  op_mode_e op_r;
  op_mode_e op_nxt;
  logic local_r;
  logic lock_q;
  logic loc_run_r;
  logic loc_run_nxt;
  logic loc_dir_r;
  logic loc_dir_nxt;
  logic [15:0] local_freq_r;
  logic [5:0] keys_q;
  logic hold_pulse;

  // Bus decode; one wait cycle then the answer
  wire wr_go = i_write && !wait_r;
  wire rd_cap = i_read && wait_r;
  wire sel_ctrl = (i_address == mode_sel_pkg::OFS_CTRL);
  wire sel_lo = (i_address == mode_sel_pkg::OFS_FUNC_LO);
  wire sel_hi = (i_address == mode_sel_pkg::OFS_FUNC_HI);
  wire sel_st = (i_address == mode_sel_pkg::OFS_STATUS);
  wire [1:0] rss = ctrl_r[mode_sel_pkg::CTRL_RSS_LSB +: 2];
  wire lcd_view = ctrl_r[mode_sel_pkg::CTRL_LCD_BIT];
  wire [2:0] link_source_indicator_en = ctrl_r[mode_sel_pkg::CTRL_LINK_SOURCE_INDICATOR_LSB +: 3];
  wire [31:0] status_w = {25'h0, o_lcd_run_status, lock_q, loc_dir_r,
    loc_run_r, local_r, op_r};
  wire [31:0] rd_w = sel_ctrl ? ctrl_r : sel_lo ? func_lo_r :
    sel_hi ? func_hi_r : sel_st ? status_w : 32'h00000000;

  // Key press edges: fwd, rev, stop, prg, reset
  wire [5:0] keys = {1'b0, i_key_reset, i_key_prg, i_key_stop,
    i_key_rev, i_key_fwd};
  wire [5:0] press = keys & ~keys_q;

  // Remote/local hold key; long hold makes one pulse
  key_hold_timer #(
    .CNT_W(mode_sel_pkg::HOLD_CNT_W),
    .HOLD_CYC(HOLD_CYC)
  ) u_hold (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_key(i_key_remloc),
    .o_held(hold_pulse)
  );

  // Priority terminal; the input overrides the key toggle
  wire lock_now = lock_hit({func_hi_r[23:0], func_lo_r},
    {i_din_extra, i_din});
  wire local_nxt = lock_now ? 1'b1 :
    (lock_q ? 1'b0 : (hold_pulse ? !local_r : local_r));
  wire to_local = !local_r && local_nxt;
  wire rem_running = i_remote_run_fwd || i_remote_run_rev;
  wire key_ok = (op_r != mode_sel_pkg::OP_ALARM) && local_r;

  // Operation mode; an alarm wins over any key
  always_comb
  begin
    op_nxt = op_r;
    if (i_alarm)
      op_nxt = mode_sel_pkg::OP_ALARM;
    else
      unique case (op_r)
        mode_sel_pkg::OP_RUNNING:
          if (press[3]) op_nxt = mode_sel_pkg::OP_PROGRAMMING;
        mode_sel_pkg::OP_PROGRAMMING:
          if (press[3]) op_nxt = mode_sel_pkg::OP_RUNNING;
        mode_sel_pkg::OP_ALARM:
          if (press[4]) op_nxt = mode_sel_pkg::OP_RUNNING;
        default: op_nxt = mode_sel_pkg::OP_RUNNING;
      endcase
  end

  // Local run command; stop key beats run keys pressed together
  always_comb
  begin
    loc_run_nxt = loc_run_r;
    loc_dir_nxt = loc_dir_r;
    if (op_r == mode_sel_pkg::OP_ALARM || !local_nxt)
      loc_run_nxt = 1'b0;
    else if (to_local)
    begin
      loc_dir_nxt = i_remote_run_rev;
      loc_run_nxt = rem_running &&
        dir_ok(rss, i_remote_run_rev);
    end
    else if (key_ok)
    begin
      if (press[2])
        loc_run_nxt = 1'b0;
      else if (press[0] && dir_ok(rss, 1'b0))
      begin
        loc_run_nxt = 1'b1;
        loc_dir_nxt = 1'b0;
      end
      else if (press[1] && dir_ok(rss, 1'b1))
      begin
        loc_run_nxt = 1'b1;
        loc_dir_nxt = 1'b1;
      end
    end
  end

  // Effective command source and panel outputs
  wire run_fwd_w = local_r ? (loc_run_r && !loc_dir_r)
    : i_remote_run_fwd;
  wire run_rev_w = local_r ? (loc_run_r && loc_dir_r) : i_remote_run_rev;
  wire [15:0] freq_w = local_r ? local_freq_r : i_remote_freq;
  wire run_stat_w = run_fwd_w || run_rev_w || i_motor_driving;
  wire keypad_source_indicator_w = local_r || (rss != mode_sel_pkg::RSS_EXTERNAL);

  // Bus slave and settings
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      wait_r <= 1'b1;
      o_readdata <= 32'h00000000;
      ctrl_r <= mode_sel_pkg::CTRL_RST;
      func_lo_r <= mode_sel_pkg::FUNC_LO_RST;
      func_hi_r <= mode_sel_pkg::FUNC_HI_RST;
    end
    else
    begin
      wait_r <= !((i_read || i_write) && wait_r);
      if (rd_cap)
        o_readdata <= rd_w;
      if (wr_go && sel_ctrl)
        ctrl_r <= merge(ctrl_r, i_writedata, i_byteenable);
      if (wr_go && sel_lo)
        func_lo_r <= merge(func_lo_r, i_writedata, i_byteenable);
      if (wr_go && sel_hi)
        func_hi_r <= merge(func_hi_r, i_writedata, i_byteenable);
    end
  end

  assign o_waitrequest = wait_r;

  // Mode state
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      op_r <= mode_sel_pkg::OP_RUNNING;
      local_r <= 1'b0;
      lock_q <= 1'b0;
      loc_run_r <= 1'b0;
      loc_dir_r <= 1'b0;
      local_freq_r <= 16'h0000;
      keys_q <= 6'h00;
    end
    else
    begin
      op_r <= op_nxt;
      local_r <= local_nxt;
      lock_q <= lock_now;
      loc_run_r <= loc_run_nxt;
      loc_dir_r <= loc_dir_nxt;
      keys_q <= keys;
      if (to_local)
        local_freq_r <= i_remote_freq;
    end
  end

  // Registered outputs
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_run_fwd <= 1'b0;
      o_run_rev <= 1'b0;
      o_freq_cmd <= 16'h0000;
      o_mode <= 2'h0;
      o_remote_ind <= 1'b0;
      o_local_ind <= 1'b0;
      o_keypad_src_ind <= 1'b0;
      o_link_src_ind <= 1'b0;
      o_scale_ind <= 1'b0;
      o_fwd_ind <= 1'b0;
      o_rev_ind <= 1'b0;
      o_stop_ind <= 1'b0;
      o_lcd_status_view <= 1'b0;
      o_lcd_bar_view <= 1'b0;
      o_lcd_run_status <= 1'b0;
      o_bar_freq <= 8'h00;
      o_bar_current <= 8'h00;
      o_bar_torque <= 8'h00;
    end
    else
    begin
      o_run_fwd <= run_fwd_w;
      o_run_rev <= run_rev_w;
      o_freq_cmd <= freq_w;
      o_mode <= op_r;
      o_remote_ind <= !local_r;
      o_local_ind <= local_r;
      o_keypad_src_ind <= keypad_source_indicator_w;
      o_link_src_ind <= |link_source_indicator_en;
      o_scale_ind <= i_display_value > mode_sel_pkg::SCALE_LIMIT;
      o_fwd_ind <= run_fwd_w;
      o_rev_ind <= run_rev_w;
      o_stop_ind <= !run_stat_w;
      o_lcd_status_view <= !lcd_view;
      o_lcd_bar_view <= lcd_view;
      o_lcd_run_status <= run_stat_w;
      o_bar_freq <= bar_level(i_out_freq, 18'(i_max_freq));
      o_bar_current <= bar_level(i_out_current, rated_full(i_rated_current));
      o_bar_torque <= bar_level(i_torque, rated_full(i_rated_torque));
    end
  end

  // Checks; all in the single clock domain
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  power_up_running_a: assert property (
    $past(!i_rst_n) |-> op_r == mode_sel_pkg::OP_RUNNING)
    else $error("not in running mode after reset");
  alarm_entry_a: assert property (
    i_alarm |=> op_r == mode_sel_pkg::OP_ALARM ##1 o_mode == 2'h2)
    else $error("alarm did not enter alarm mode");
  alarm_keys_a: assert property (
    op_r == mode_sel_pkg::OP_ALARM |=> !loc_run_r)
    else $error("local run held in alarm mode");
  keypad_fwd_a: assert property (
    key_ok && local_nxt && !to_local && press[0] && !press[2] &&
    rss == mode_sel_pkg::RSS_KEYPAD |=> loc_run_r && !loc_dir_r
    ##1 o_run_fwd)
    else $error("forward key did not start");
  rev_disabled_a: assert property (
    key_ok && local_nxt && !to_local && !loc_run_r && press[1] &&
    !press[0] && rss == mode_sel_pkg::RSS_KEY_FWD |=> !loc_run_r)
    else $error("reverse key ran in forward-only");
  fwd_disabled_a: assert property (
    key_ok && local_nxt && !to_local && !loc_run_r && press[0] &&
    !press[1] && rss == mode_sel_pkg::RSS_KEY_REV |=> !loc_run_r)
    else $error("forward key ran in reverse-only");
  hold_toggle_a: assert property (
    hold_pulse && !lock_now && !lock_q |=> local_r != $past(local_r))
    else $error("long hold did not toggle");
  lock_local_a: assert property (
    lock_now |=> local_r ##1 o_local_ind)
    else $error("priority input did not force local");
  lock_release_a: assert property (
    lock_q && !lock_now |=> !local_r)
    else $error("priority release did not return remote");
  freq_carry_a: assert property (
    to_local |=> local_freq_r == $past(i_remote_freq)
    ##1 o_freq_cmd == $past(i_remote_freq, 2))
    else $error("remote frequency not carried");
  run_carry_a: assert property (
    to_local && op_r != mode_sel_pkg::OP_ALARM && rem_running &&
    dir_ok(rss, i_remote_run_rev) |=> loc_run_r)
    else $error("run not carried to local");
  dir_conflict_a: assert property (
    to_local && !dir_ok(rss, i_remote_run_rev) |=> !loc_run_r)
    else $error("conflicting direction kept running");
  scale_ind_a: assert property (
    i_display_value > mode_sel_pkg::SCALE_LIMIT |=> o_scale_ind)
    else $error("scale indicator off");
  run_status_a: assert property (
    o_run_fwd || o_run_rev |-> o_lcd_run_status && !o_stop_ind)
    else $error("run status not shown");

  alarm_seen_c: cover property (op_r == mode_sel_pkg::OP_ALARM);
  carry_run_c: cover property (to_local && rem_running);
  hold_toggle_c: cover property (hold_pulse ##1 local_r);
  bar_view_c: cover property (o_lcd_bar_view && o_run_fwd);
endmodule // drive_operation_mode_selector

// ===== verilog/key_hold_timer.sv
// Hold timer for the remote/local key.
// Assumes the key level is already synchronous and debounced.
`timescale 1ns/10ps
module key_hold_timer #(
  parameter int CNT_W = 27,
  parameter int unsigned HOLD_CYC = 100000000
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Key level and hold pulse
  input wire logic i_key,
  output logic o_held
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic held_nxt;

  // Count saturates so a long hold fires only once
  assign cnt_nxt = !i_key ? '0 :
    (cnt_r == CNT_W'(HOLD_CYC)) ? cnt_r : cnt_r + 1'b1;
  assign held_nxt = i_key && (cnt_r == CNT_W'(HOLD_CYC - 1));

  // Counter and one-cycle pulse
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= '0;
      o_held <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      o_held <= held_nxt;
    end
  end
endmodule // key_hold_timer

// ===== verilog/mode_sel_pkg.sv
// Constants shared by the operation mode selector.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package mode_sel_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int HOLD_TIME_MS = 1000;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * 1000 * CLK_MHZ;
  localparam int HOLD_CNT_W = 27;
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_FUNC_LO = 5'h04;
  localparam logic [4:0] OFS_FUNC_HI = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  // Control register fields
  localparam int CTRL_RSS_LSB = 0;
  localparam int CTRL_LCD_BIT = 2;
  localparam int CTRL_LINK_SOURCE_INDICATOR_LSB = 3;
  // Reset values; terminal five carries the keypad-priority code
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] FUNC_LO_RST = 32'h00000000;
  localparam logic [31:0] FUNC_HI_RST = 32'h00000023;
  // Run source codes
  localparam logic [1:0] RSS_KEYPAD = 2'h0;
  localparam logic [1:0] RSS_EXTERNAL = 2'h1;
  localparam logic [1:0] RSS_KEY_FWD = 2'h2;
  localparam logic [1:0] RSS_KEY_REV = 2'h3;
  // Terminal function code for keypad priority
  localparam logic [7:0] LOCK_FUNC_CODE = 8'h23;
  localparam int TERMINALS = 7;
  // Display limits
  localparam logic [31:0] SCALE_LIMIT = 32'h0001869F;
  localparam logic [7:0] BAR_FULL = 8'hFF;
  localparam int BAR_PCT = 200;
  // Operation modes
  typedef enum logic [1:0] {OP_RUNNING, OP_PROGRAMMING, OP_ALARM} op_mode_e;
endpackage
